// >>> logic/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_WDO_HOLD_CYC    7'd66
`define RSC_SYS_HOLD_CYC    5'd16
`define RSC_PIN_MIN_CYC     3'd4
`define RSC_VEC_ADDR_HI     16'h0002
`define RSC_VEC_ADDR_LO     16'h0003
`define RSC_WATCHDOG_RESET_OPTION_DEFAULT 1'b1
`define RSC_SYNC_IDLE       6'h08
`define RSC_CAUSE_POR       0
`define RSC_CAUSE_STOP      1
`define RSC_CAUSE_WDT       2
`define RSC_CAUSE_EXT       3
`endif

// >>> logic/rsc_pkg.sv
package rsc_pkg;
    typedef enum logic [2:0] {
        RSC_RUN,
        RSC_HALT,
        RSC_STOP,
        RSC_HOLD_WDO,
        RSC_HOLD_SYS,
        RSC_WAIT_PIN
    } rsc_state_e;

    typedef struct packed {
        logic external_pin_cause_bit;
        logic wdt;
        logic stop;
        logic por;
    } rsc_cause_s;

    typedef struct packed {
        logic core_run;
        logic sysclk_run;
        logic xtal_stop;
        logic periph_idle;
        logic wdt_run;
        logic bo_run;
    } rsc_power_s;
endpackage

// >>> logic/rsc_ctrl.sv
// Behaviour
// - after power good, count 66 watchdog-oscillator cycles
// - then count 16 system clock cycles
// - hold core reset until both counts expire
// - power-on completion sets power-on cause bit
// - brown-out holds reset, reruns full sequence
// - brown-out in stop follows always-on option
// - watchdog timeout resets when reset option set
// - watchdog reset sets watchdog cause bit
// - reset pin low four cycles starts reset
// - pin low holds reset; release on deassert
// - pin reset sets external cause bit
// - debugger reset spares debug block, self-clears
// - stop recovery holds 66 plus 16 cycles
// - stop recovery changes only watchdog status
// - core fetches vector at 0002H and 0003H
// - every stop recovery sets stop cause bit
// - watchdog in stop: recovery, both causes, irq if enabled and reset option clear
// - any edge on enabled wake pin recovers
// - port inputs frozen in stop and through the recovery hold until release
// - stop halts clocks, xtal high/low, peripherals idle
// - halt stops only the core; clock, peripherals and watchdog keep running
// - halt left on irq, watchdog, resets
// - power-on and brown-out beat every source
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
module rsc_ctrl
    import rsc_pkg::*;
#(
    parameter int GPIO_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              supply_ok,
    input  wire logic              brownout_monitor,
    input  wire logic              brownout_always_on_option,
    input  wire logic              watchdog_reset_option,
    input  wire logic              wdo_tick,
    input  wire logic              wdt_timeout,
    input  wire logic              wdt_run_in_stop,
    input  wire logic              reset_pin_n,
    input  wire logic              dbg_reset_req,
    input  wire logic              stop_req,
    input  wire logic              halt_req,
    input  wire logic              irq_pending,
    input  wire logic              irq_enable,
    input  wire logic [GPIO_W-1:0] gpio_in,
    input  wire logic [GPIO_W-1:0] gpio_wake_en,
    input  wire logic              cause_clear,
    output logic                   core_reset,
    output logic                   periph_reset,
    output logic                   dbg_reset_clear,
    output logic                   load_vector,
    output logic [15:0]            vector_addr_hi,
    output logic [15:0]            vector_addr_lo,
    output logic                   wdt_irq_service,
    output rsc_power_s             power_ctl,
    output rsc_cause_s             watchdog_control_status_reg,
    output logic [GPIO_W-1:0]      port_input_data_reg
);
    // the wake mask and the synchroniser word are sized from this width
    if (GPIO_W < 1 || GPIO_W > 64) begin : g_bad_width
        $error("GPIO_W out of range");
    end

    // two-flop synchronisers for every asynchronous input
    localparam int SW = 6 + GPIO_W;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // idle levels: supply reads bad, reset pin reads released
            sync1_r <= {`RSC_SYNC_IDLE, {GPIO_W{1'b0}}};
            sync2_r <= {`RSC_SYNC_IDLE, {GPIO_W{1'b0}}};
        end else begin
            sync1_r <= {supply_ok, brownout_monitor, reset_pin_n, wdo_tick,
                        wdt_timeout, dbg_reset_req, gpio_in};
            sync2_r <= sync1_r;
        end
    end
    logic              s_supply;
    logic              s_bo;
    logic              s_pin_n;
    logic              s_wdo;
    logic              s_wdt;
    logic              s_dbg;
    logic [GPIO_W-1:0] s_gpio;
    assign {s_supply, s_bo, s_pin_n, s_wdo, s_wdt, s_dbg, s_gpio} = sync2_r;

    // edge detectors on synchronised levels
    logic              wdo_d_r;
    logic              wdt_d_r;
    logic              dbg_d_r;
    logic [GPIO_W-1:0] gpio_d_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdo_d_r  <= 1'b0;
            wdt_d_r  <= 1'b0;
            dbg_d_r  <= 1'b0;
            gpio_d_r <= '0;
        end else begin
            wdo_d_r  <= s_wdo;
            wdt_d_r  <= s_wdt;
            dbg_d_r  <= s_dbg;
            gpio_d_r <= s_gpio;
        end
    end
    logic wdo_pulse;
    logic wdt_pulse;
    logic dbg_pulse;
    assign wdo_pulse = s_wdo & ~wdo_d_r;
    assign wdt_pulse = s_wdt & ~wdt_d_r;
    assign dbg_pulse = s_dbg & ~dbg_d_r;

    rsc_state_e state_r;

    // pin low-time filter
    logic [2:0] pin_cnt_r;
    logic       pin_hit;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_cnt_r <= 3'd0;
        end else if (s_pin_n) begin
            pin_cnt_r <= 3'd0;
        end else if (pin_cnt_r != `RSC_PIN_MIN_CYC) begin
            pin_cnt_r <= pin_cnt_r + 3'd1;
        end
    end
    // one event per assertion: a pin held low lets the hold-off run on,
    // so release can follow the pin as soon as it goes high
    assign pin_hit = ~s_pin_n & (pin_cnt_r == `RSC_PIN_MIN_CYC - 3'd1);

    logic in_stop;
    assign in_stop = (state_r == RSC_STOP);
    logic bo_active;
    assign bo_active = ~in_stop | brownout_always_on_option;
    logic power_bad;
    assign power_bad = ~s_supply | (s_bo & bo_active);
    logic wdt_reset_ev;
    assign wdt_reset_ev = wdt_pulse & watchdog_reset_option & ~in_stop;
    logic wake_ev;
    assign wake_ev = in_stop & |((s_gpio ^ gpio_d_r) & gpio_wake_en);
    logic wdt_stop_ev;
    assign wdt_stop_ev = in_stop & wdt_pulse & wdt_run_in_stop;
    logic sys_reset_ev;
    assign sys_reset_ev = pin_hit | wdt_reset_ev | dbg_pulse;

    logic [6:0] wdo_cnt_r;
    logic [4:0] sys_cnt_r;
    logic       is_recovery_r;
    logic       pend_por_r;
    logic       pend_wdt_r;
    logic       pend_ext_r;

    // main sequencer; power loss pre-empts every branch
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r       <= RSC_HOLD_WDO;
            wdo_cnt_r     <= 7'd0;
            sys_cnt_r     <= 5'd0;
            is_recovery_r <= 1'b0;
        end else if (power_bad) begin
            state_r       <= RSC_HOLD_WDO;
            wdo_cnt_r     <= 7'd0;
            sys_cnt_r     <= 5'd0;
            is_recovery_r <= 1'b0;
        end else if (sys_reset_ev) begin
            state_r       <= RSC_HOLD_WDO;
            wdo_cnt_r     <= 7'd0;
            sys_cnt_r     <= 5'd0;
            is_recovery_r <= 1'b0;
        end else begin
            case (state_r)
                RSC_RUN: begin
                    // stop wins when both low-power requests arrive together
                    if (stop_req) begin
                        state_r <= RSC_STOP;
                    end else if (halt_req) begin
                        state_r <= RSC_HALT;
                    end
                end
                RSC_HALT: begin
                    if (irq_pending | wdt_pulse) begin
                        state_r <= RSC_RUN;
                    end
                end
                RSC_STOP: begin
                    if (wake_ev | wdt_stop_ev) begin
                        state_r       <= RSC_HOLD_WDO;
                        wdo_cnt_r     <= 7'd0;
                        sys_cnt_r     <= 5'd0;
                        is_recovery_r <= 1'b1;
                    end
                end
                RSC_HOLD_WDO: begin
                    // the slow tick must stay under half of sys_clk to be seen
                    if (wdo_pulse) begin
                        if (wdo_cnt_r == `RSC_WDO_HOLD_CYC - 7'd1) begin
                            state_r <= RSC_HOLD_SYS;
                        end else begin
                            wdo_cnt_r <= wdo_cnt_r + 7'd1;
                        end
                    end
                end
                RSC_HOLD_SYS: begin
                    if (sys_cnt_r == `RSC_SYS_HOLD_CYC - 5'd1) begin
                        state_r <= s_pin_n ? RSC_RUN : RSC_WAIT_PIN;
                    end else begin
                        sys_cnt_r <= sys_cnt_r + 5'd1;
                    end
                end
                RSC_WAIT_PIN: begin
                    if (s_pin_n) begin
                        state_r <= RSC_RUN;
                    end
                end
                default: begin
                    state_r <= RSC_HOLD_WDO;
                end
            endcase
        end
    end

    // pin held low keeps reset through the count; a fresh assertion restarts it
    logic release_ev;
    assign release_ev = ~power_bad & ~sys_reset_ev &
                        (((state_r == RSC_HOLD_SYS) & s_pin_n &
                          (sys_cnt_r == `RSC_SYS_HOLD_CYC - 5'd1)) |
                         ((state_r == RSC_WAIT_PIN) & s_pin_n));

    // cause tracking: pending bits land when the hold-off ends
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pend_por_r <= 1'b1;
            pend_wdt_r <= 1'b0;
            pend_ext_r <= 1'b0;
        end else if (power_bad | dbg_pulse) begin
            pend_por_r <= 1'b1;
            pend_wdt_r <= 1'b0;
            pend_ext_r <= 1'b0;
        end else if (release_ev) begin
            pend_por_r <= 1'b0;
            pend_wdt_r <= 1'b0;
            pend_ext_r <= 1'b0;
        end else begin
            if (wdt_reset_ev | wdt_stop_ev) begin
                pend_wdt_r <= 1'b1;
            end
            if (pin_hit) begin
                pend_ext_r <= 1'b1;
            end
        end
    end

    // set wins over software clear; recovery touches only this register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            watchdog_control_status_reg <= '0;
        end else if (release_ev) begin
            watchdog_control_status_reg.por  <= pend_por_r;
            watchdog_control_status_reg.wdt  <= pend_wdt_r;
            watchdog_control_status_reg.external_pin_cause_bit  <= pend_ext_r;
            watchdog_control_status_reg.stop <= is_recovery_r;
        end else if (cause_clear) begin
            watchdog_control_status_reg <= '0;
        end
    end

    // core / peripheral reset; peripherals untouched by stop recovery
    logic holding;
    assign holding = (state_r == RSC_HOLD_WDO) | (state_r == RSC_HOLD_SYS) |
                     (state_r == RSC_WAIT_PIN);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            core_reset      <= 1'b1;
            periph_reset    <= 1'b1;
            dbg_reset_clear <= 1'b0;
            load_vector     <= 1'b0;
            wdt_irq_service <= 1'b0;
        end else begin
            core_reset      <= (holding & ~release_ev) | power_bad | sys_reset_ev;
            periph_reset    <= ((holding & ~release_ev & ~is_recovery_r) | power_bad |
                                sys_reset_ev);
            dbg_reset_clear <= dbg_pulse;
            load_vector     <= release_ev;
            wdt_irq_service <= release_ev & is_recovery_r & pend_wdt_r &
                               ~watchdog_reset_option & irq_enable;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            vector_addr_hi <= '0;
            vector_addr_lo <= '0;
        end else begin
            vector_addr_hi <= `RSC_VEC_ADDR_HI;
            vector_addr_lo <= `RSC_VEC_ADDR_LO;
        end
    end

    // port inputs frozen in stop and during recovery; short wake pulses never land
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            port_input_data_reg <= '0;
        end else if (~in_stop & ~(holding & is_recovery_r)) begin
            port_input_data_reg <= s_gpio;
        end
    end

    // power control outputs
    logic in_halt;
    assign in_halt = (state_r == RSC_HALT);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            power_ctl <= '0;
        end else begin
            power_ctl.core_run    <= ~holding & ~in_stop & ~in_halt;
            power_ctl.sysclk_run  <= ~in_stop & (state_r != RSC_HOLD_WDO);
            power_ctl.xtal_stop   <= in_stop;
            power_ctl.periph_idle <= in_stop | holding;
            power_ctl.wdt_run     <= ~in_stop | wdt_run_in_stop;
            power_ctl.bo_run      <= bo_active;
        end
    end
endmodule
`default_nettype wire

// >>> bench/rsc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_far_model (
    input  wire logic sys_clk,
    input  wire logic osc_en,
    output logic      wdo_tick
);
    logic [1:0] div_r = 2'b00;
    // slow rc oscillator: one rising edge every 4 system clocks, free running in reset
    always_ff @(posedge sys_clk) begin
        if (osc_en) begin
            div_r <= div_r + 2'd1;
        end
    end
    assign wdo_tick = div_r[1];
endmodule
`default_nettype wire

// >>> bench/rsc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_chk
    import rsc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        supply_ok,
    input wire logic        brownout_always_on_option,
    input wire logic        core_reset,
    input wire logic        load_vector,
    input wire logic [15:0] vector_addr_hi,
    input wire logic [15:0] vector_addr_lo,
    input wire rsc_power_s  power_ctl,
    input wire rsc_cause_s  watchdog_control_status_reg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    power_fail_a: assert property ((!supply_ok) [*6] |-> core_reset)
        else $error("core not held in reset on power loss");
    vector_addr_a: assert property (load_vector |-> vector_addr_hi == 16'h0002
        && vector_addr_lo == 16'h0003) else $error("wrong vector address");
    load_pulse_a: assert property (load_vector |=> !load_vector)
        else $error("vector load longer than one cycle");
    sys_hold_a: assert property ($fell(core_reset) |-> $past(core_reset, 16))
        else $error("reset released before system clock hold");
    cause_set_a: assert property ($fell(core_reset) |-> ##[0:2] (|watchdog_control_status_reg))
        else $error("no cause recorded at release");
    stop_clocks_a: assert property (power_ctl.xtal_stop |-> !power_ctl.sysclk_run
        && !power_ctl.core_run && power_ctl.periph_idle) else $error("clocks run in stop");
    halt_run_a: assert property (!core_reset && $past(core_reset, 2) == 1'b0
        && !power_ctl.core_run && !power_ctl.xtal_stop |-> power_ctl.sysclk_run
        && !power_ctl.periph_idle) else $error("halt stopped more than the core");
    stop_bo_a: assert property (power_ctl.xtal_stop && $past(power_ctl.xtal_stop)
        && $stable(brownout_always_on_option) |-> power_ctl.bo_run == brownout_always_on_option)
        else $error("brownout monitor ignores option in stop");
    cover property ($fell(core_reset));
    cover property ($rose(power_ctl.xtal_stop));
    cover property (!core_reset && !power_ctl.core_run && power_ctl.sysclk_run);
endmodule
bind rsc_ctrl rsc_ctrl_chk u_rsc_ctrl_chk (.sys_clk(sys_clk), .rstn(rstn),
    .supply_ok(supply_ok), .brownout_always_on_option(brownout_always_on_option),
    .core_reset(core_reset), .load_vector(load_vector), .vector_addr_hi(vector_addr_hi),
    .vector_addr_lo(vector_addr_lo), .power_ctl(power_ctl),
    .watchdog_control_status_reg(watchdog_control_status_reg));
`default_nettype wire

// >>> bench/rsc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_tb;
    import rsc_pkg::*;
    // hold window: 66 slow ticks of 4 clocks, 16 clocks, plus sync slack
    localparam int HOLD_MIN = 65 * 4 + 16;
    localparam int HOLD_MAX = 66 * 4 + 16 + 14;
    logic sys_clk = 1'b0, rstn = 1'b0, supply_ok = 1'b1, brownout_monitor = 1'b0;
    logic brownout_always_on_option = 1'b1, watchdog_reset_option = 1'b1, wdt_timeout = 1'b0;
    logic wdt_run_in_stop = 1'b0, reset_pin_n = 1'b1, dbg_reset_req = 1'b0, stop_req = 1'b0;
    logic halt_req = 1'b0, irq_pending = 1'b0, irq_enable = 1'b0, cause_clear = 1'b0;
    logic [7:0] gpio_in = 8'h00, gpio_wake_en = 8'h00, port_input_data_reg;
    logic core_reset, periph_reset, dbg_reset_clear, load_vector, wdt_irq_service, wdo_tick;
    logic [15:0] vector_addr_hi, vector_addr_lo;
    rsc_power_s power_ctl;
    rsc_cause_s watchdog_control_status_reg;
    logic lv_seen = 1'b0, irq_seen = 1'b0;
    int n_errors = 0, checks = 0, n;
    logic pr;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (load_vector === 1'b1) lv_seen <= 1'b1;
        if (wdt_irq_service === 1'b1) irq_seen <= 1'b1;
    end
    rsc_far_model u_rsc_far_model (.sys_clk, .osc_en(1'b1), .wdo_tick);
    rsc_ctrl u_rsc_ctrl (.sys_clk, .rstn, .supply_ok, .brownout_monitor,
        .brownout_always_on_option, .watchdog_reset_option, .wdo_tick, .wdt_timeout,
        .wdt_run_in_stop, .reset_pin_n, .dbg_reset_req, .stop_req, .halt_req, .irq_pending,
        .irq_enable, .gpio_in, .gpio_wake_en, .cause_clear, .core_reset, .periph_reset,
        .dbg_reset_clear, .load_vector, .vector_addr_hi, .vector_addr_lo, .wdt_irq_service,
        .power_ctl, .watchdog_control_status_reg, .port_input_data_reg);
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // waits for entry into reset, then counts the hold until release
    task automatic rel(input logic [3:0] st, input int tag_lo, input int tag_hi);
        n = 0;
        pr = 1'b0;
        while (core_reset !== 1'b1 && n < 40) begin cyc(1); n++; end
        n = 0;
        while (core_reset !== 1'b0 && n < 2000) begin cyc(1); n++; pr |= periph_reset; end
        cyc(4);
        chk("hold_len_min", 16'(n >= tag_lo), 16'h0001);
        chk("hold_len_max", 16'(n <= tag_hi), 16'h0001);
        chk("vector_load", lv_seen, 1'b1);
        chk("cause", 16'(watchdog_control_status_reg), 16'(st));
        lv_seen = 1'b0;
    endtask
    task automatic t_pin;
        reset_pin_n <= 1'b0;
        cyc(3);
        reset_pin_n <= 1'b1;
        cyc(12);
        chk("short_pin", core_reset, 1'b0);
        reset_pin_n <= 1'b0;
        cyc(8);
        reset_pin_n <= 1'b1;
        rel(4'b1000, HOLD_MIN - 8, HOLD_MAX);
        reset_pin_n <= 1'b0;
        cyc(420);
        chk("pin_hold", core_reset, 1'b1);
        reset_pin_n <= 1'b1;
        rel(4'b1000, 0, 10);
    endtask
    task automatic t_wdt;
        watchdog_reset_option <= 1'b0;
        wdt_timeout <= 1'b1;
        cyc(2);
        wdt_timeout <= 1'b0;
        cyc(12);
        chk("wdt_no_reset", core_reset, 1'b0);
        watchdog_reset_option <= 1'b1;
        wdt_timeout <= 1'b1;
        cyc(2);
        wdt_timeout <= 1'b0;
        rel(4'b0100, HOLD_MIN, HOLD_MAX);
        chk("periph_rst", pr, 1'b1);
    endtask
    task automatic t_brown;
        supply_ok <= 1'b0;
        brownout_monitor <= 1'b1;
        cyc(30);
        chk("bo_hold", core_reset, 1'b1);
        supply_ok <= 1'b1;
        brownout_monitor <= 1'b0;
        rel(4'b0001, HOLD_MIN, HOLD_MAX);
    endtask
    task automatic t_dbg;
        dbg_reset_req <= 1'b1;
        n = 0;
        while (dbg_reset_clear !== 1'b1 && n < 40) begin cyc(1); n++; end
        chk("dbg_self_clear", dbg_reset_clear, 1'b1);
        dbg_reset_req <= 1'b0;
        rel(4'b0001, HOLD_MIN - 40, HOLD_MAX);
    endtask
    task automatic enter_stop;
        stop_req <= 1'b1;
        cyc(1);
        stop_req <= 1'b0;
        cyc(8);
        chk("xtal_stop", power_ctl.xtal_stop, 1'b1);
    endtask
    task automatic t_stop;
        gpio_wake_en <= 8'h04;
        enter_stop();
        gpio_in <= 8'h20;
        cyc(12);
        chk("masked_pin", power_ctl.xtal_stop, 1'b1);
        brownout_always_on_option <= 1'b0;
        brownout_monitor <= 1'b1;
        cyc(8);
        chk("bo_off_stop", power_ctl.xtal_stop, 1'b1);
        chk("bo_run_stop", power_ctl.bo_run, 1'b0);
        brownout_monitor <= 1'b0;
        cyc(4);
        brownout_always_on_option <= 1'b1;
        cyc(4);
        gpio_in <= 8'h24;
        rel(4'b0010, HOLD_MIN, HOLD_MAX);
        chk("periph_kept", pr, 1'b0);
        chk("port_capture", port_input_data_reg, 8'h24);
        wdt_run_in_stop <= 1'b1;
        irq_enable <= 1'b1;
        watchdog_reset_option <= 1'b0;
        irq_seen = 1'b0;
        enter_stop();
        wdt_timeout <= 1'b1;
        cyc(2);
        wdt_timeout <= 1'b0;
        rel(4'b0110, HOLD_MIN, HOLD_MAX);
        cyc(16);
        chk("wdt_irq", irq_seen, 1'b1);
        watchdog_reset_option <= 1'b1;
    endtask
    task automatic t_halt;
        halt_req <= 1'b1;
        cyc(1);
        halt_req <= 1'b0;
        cyc(8);
        chk("halt_core", power_ctl.core_run, 1'b0);
        chk("halt_clk", power_ctl.sysclk_run, 1'b1);
        irq_pending <= 1'b1;
        cyc(8);
        chk("halt_wake", power_ctl.core_run, 1'b1);
        irq_pending <= 1'b0;
        cyc(4);
        cause_clear <= 1'b1;
        cyc(1);
        cause_clear <= 1'b0;
        cyc(1);
        chk("cause_clear", 16'(watchdog_control_status_reg), 16'h0000);
    endtask
    task automatic end_sim;
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        cyc(12000);
        n_errors++;
        end_sim();
    end
    initial begin
        cyc(16);
        rstn <= 1'b1;
        rel(4'b0001, HOLD_MIN, HOLD_MAX);
        t_pin();
        t_wdt();
        t_brown();
        t_dbg();
        t_halt();
        t_stop();
        end_sim();
    end
endmodule
`default_nettype wire
